// [dsf_defines.svh]
// Function
// - Bit 0 of register 0x000C reads 1 while the whole device is calibrating.
// - Bit 2 of register 0x000C reads 1 while the reference input signal is insufficient.
// - Bit 3 of register 0x000C reads 1 while the reference input is not locked.
// - Bit 5 of register 0x000C reads 1 while a management-bus timeout is indicated.
// - Bit 5 of register 0x000F reads 1 while the main PLL is calibrating.
// - A sticky flag sets when its indicator shows a fault and holds until software clears it.
// - Writing 0 to a sticky flag clears it only when its indicator is no longer asserted.
// - System calibration, signal loss and lock error flags sit at bits 0, 2 and 3 of 0x0011.
// - The bus timeout flag sits at bit 5 of 0x0011 with the same set and clear behaviour.
// - Each flag has a mask bit, 0 lets it drive the interrupt and 1 blocks it, reset to 0.
// - The active-low interrupt stays low until every unmasked set flag has been cleared.
`ifndef DSF_DEFINES_SVH
`define DSF_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------------------------------
`define DSF_IDX_LIVE_A   8'h0c
`define DSF_IDX_LIVE_B   8'h0f
`define DSF_IDX_FLAG_A   8'h11
`define DSF_IDX_FLAG_B   8'h14
`define DSF_IDX_MASK_A   8'h17
`define DSF_IDX_MASK_B   8'h1a

// ----------------------------------------------------------------
// Bit positions inside the data byte
// ----------------------------------------------------------------
`define DSF_BIT_SYSCAL   0
`define DSF_BIT_REFLOS   2
`define DSF_BIT_LOCKERR  3
`define DSF_BIT_TMOUT    5
`define DSF_BIT_PLLCAL   5

// ----------------------------------------------------------------
// Slots in the internal flag vector
// ----------------------------------------------------------------
`define DSF_N_FLAGS      5
`define DSF_SL_SYSCAL    0
`define DSF_SL_REFLOS    1
`define DSF_SL_LOCKERR   2
`define DSF_SL_TMOUT     3
`define DSF_SL_PLLCAL    4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DSF_RST_FLAGS    5'h00
`define DSF_RST_MASK     5'h00
`define DSF_RST_BYTE     8'h00
`define DSF_MIN_ADDR_W   7

`endif

// [dsf_pkg.sv]
package dsf_pkg;
   typedef logic [7:0] dsf_byte_t;
   typedef logic [4:0] dsf_vec_t;
endpackage

// [dsf_status_flags.sv]
// Our own choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "dsf_defines.svh"

module dsf_status_flags
#(
   parameter int ADDR_W = 8
)
(
   input  wire logic              ref_clk,
   input  wire logic              reset,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire dsf_pkg::dsf_byte_t wdata,
   input  wire logic              wr_en,
   input  wire logic              rd_en,
   output var  dsf_pkg::dsf_byte_t rdata,
   input  wire logic              system_calibrating,
   input  wire logic              reference_signal_lost,
   input  wire logic              reference_lock_error,
   input  wire logic              bus_timeout_seen,
   input  wire logic              pll_calibrating,
   output var  logic              interrupt_out_n
);
   import dsf_pkg::*;

   generate
      if (ADDR_W < `DSF_MIN_ADDR_W)
      begin : g_chk
         $error("ADDR_W too small for the register map");
      end
   endgenerate

   // ----------------------------------------------------------------
   // Map sanity
   // ----------------------------------------------------------------
   // A moved bit must still fit its byte, and DSF_IDX_MASK_B must still fit the address space
   generate
      if ($bits(dsf_vec_t) != `DSF_N_FLAGS)
      begin : g_chk_vec
         $error("flag vector width differs from flag count");
      end
      if ((`DSF_BIT_SYSCAL >= $bits(dsf_byte_t)) || (`DSF_BIT_REFLOS >= $bits(dsf_byte_t))
          || (`DSF_BIT_LOCKERR >= $bits(dsf_byte_t)))
      begin : g_chk_bit_a
         $error("register A bit outside the data byte");
      end
      if ((`DSF_BIT_TMOUT >= $bits(dsf_byte_t)) || (`DSF_BIT_PLLCAL >= $bits(dsf_byte_t)))
      begin : g_chk_bit_b
         $error("timeout or pll bit outside the data byte");
      end
      if ((`DSF_IDX_MASK_B << 2) >= (1 << ADDR_W))
      begin : g_chk_top
         $error("highest register beyond the address space");
      end
   endgenerate

   // ----------------------------------------------------------------
   // Indicator synchronisers
   // ----------------------------------------------------------------
   // Monitors run on their own clocks, so every indicator is resynced
   dsf_vec_t sync1_q;
   dsf_vec_t sync2_q;
   dsf_vec_t sync1_d;
   dsf_vec_t sync2_d;
   dsf_vec_t raw;
   dsf_vec_t live;

   assign raw[`DSF_SL_SYSCAL]  = system_calibrating;
   assign raw[`DSF_SL_REFLOS]  = reference_signal_lost;
   assign raw[`DSF_SL_LOCKERR] = reference_lock_error;
   assign raw[`DSF_SL_TMOUT]   = bus_timeout_seen;
   assign raw[`DSF_SL_PLLCAL]  = pll_calibrating;
   assign live = sync2_q;

   always_comb
   begin
      sync1_d = raw;
      sync2_d = sync1_q;
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         sync1_q <= `DSF_RST_FLAGS;
         sync2_q <= `DSF_RST_FLAGS;
      end
      else
      begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
      end
   end

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   logic [ADDR_W-3:0] idx;
   logic              aligned;
   logic              hit_live_a;
   logic              hit_live_b;
   logic              hit_flag_a;
   logic              hit_flag_b;
   logic              hit_mask_a;
   logic              hit_mask_b;

   assign idx        = addr[ADDR_W-1:2];
   assign aligned    = (addr[1:0] == 2'h0);
   assign hit_live_a = aligned && (idx == (ADDR_W-2)'(`DSF_IDX_LIVE_A));
   assign hit_live_b = aligned && (idx == (ADDR_W-2)'(`DSF_IDX_LIVE_B));
   assign hit_flag_a = aligned && (idx == (ADDR_W-2)'(`DSF_IDX_FLAG_A));
   assign hit_flag_b = aligned && (idx == (ADDR_W-2)'(`DSF_IDX_FLAG_B));
   assign hit_mask_a = aligned && (idx == (ADDR_W-2)'(`DSF_IDX_MASK_A));
   assign hit_mask_b = aligned && (idx == (ADDR_W-2)'(`DSF_IDX_MASK_B));

   // ----------------------------------------------------------------
   // Write strobes per register
   // ----------------------------------------------------------------
   // Live registers get no strobe, so writes to them are dropped
   logic wr_flag_a;
   logic wr_flag_b;
   logic wr_mask_a;
   logic wr_mask_b;

   assign wr_flag_a = wr_en && hit_flag_a;
   assign wr_flag_b = wr_en && hit_flag_b;
   assign wr_mask_a = wr_en && hit_mask_a;
   assign wr_mask_b = wr_en && hit_mask_b;

   // ----------------------------------------------------------------
   // Per-flag clear requests and mask write values
   // ----------------------------------------------------------------
   dsf_vec_t clr_req;
   dsf_vec_t mask_wr;
   dsf_vec_t mask_val;

   always_comb
   begin
      clr_req  = `DSF_RST_FLAGS;
      mask_wr  = `DSF_RST_FLAGS;
      mask_val = `DSF_RST_FLAGS;
      if (wr_flag_a)
      begin
         // Only a written 0 asks for a clear, a 1 is ignored
         clr_req[`DSF_SL_SYSCAL]  = !wdata[`DSF_BIT_SYSCAL];
         clr_req[`DSF_SL_REFLOS]  = !wdata[`DSF_BIT_REFLOS];
         clr_req[`DSF_SL_LOCKERR] = !wdata[`DSF_BIT_LOCKERR];
         clr_req[`DSF_SL_TMOUT]   = !wdata[`DSF_BIT_TMOUT];
      end
      if (wr_flag_b)
      begin
         clr_req[`DSF_SL_PLLCAL] = !wdata[`DSF_BIT_PLLCAL];
      end
      if (wr_mask_a)
      begin
         mask_wr[`DSF_SL_SYSCAL]   = 1'b1;
         mask_wr[`DSF_SL_REFLOS]   = 1'b1;
         mask_wr[`DSF_SL_LOCKERR]  = 1'b1;
         mask_wr[`DSF_SL_TMOUT]    = 1'b1;
         mask_val[`DSF_SL_SYSCAL]  = wdata[`DSF_BIT_SYSCAL];
         mask_val[`DSF_SL_REFLOS]  = wdata[`DSF_BIT_REFLOS];
         mask_val[`DSF_SL_LOCKERR] = wdata[`DSF_BIT_LOCKERR];
         mask_val[`DSF_SL_TMOUT]   = wdata[`DSF_BIT_TMOUT];
      end
      if (wr_mask_b)
      begin
         mask_wr[`DSF_SL_PLLCAL]  = 1'b1;
         mask_val[`DSF_SL_PLLCAL] = wdata[`DSF_BIT_PLLCAL];
      end
   end

   // ----------------------------------------------------------------
   // Sticky flags and masks
   // ----------------------------------------------------------------
   dsf_vec_t flag_q;
   dsf_vec_t flag_d;
   dsf_vec_t clr_ok;
   dsf_vec_t mask_q;
   dsf_vec_t mask_d;

   genvar gi;
   generate
      for (gi = 0; gi < `DSF_N_FLAGS; gi++)
      begin : g_flag
         // A clear only counts once the synced indicator has dropped
         assign clr_ok[gi] = clr_req[gi] && !live[gi];
         // Set wins: a live fault keeps the flag up whatever is written
         assign flag_d[gi] = live[gi] || (flag_q[gi] && !clr_ok[gi]);
         assign mask_d[gi] = mask_wr[gi] ? mask_val[gi] : mask_q[gi];
      end
   endgenerate

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         flag_q <= `DSF_RST_FLAGS;
      end
      else
      begin
         flag_q <= flag_d;
      end
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         mask_q <= `DSF_RST_MASK;
      end
      else
      begin
         mask_q <= mask_d;
      end
   end

   // ----------------------------------------------------------------
   // Register byte views
   // ----------------------------------------------------------------
   // Unused bit positions stay 0 so software sees a clean byte
   dsf_byte_t live_a_byte;
   dsf_byte_t live_b_byte;
   dsf_byte_t flag_a_byte;
   dsf_byte_t flag_b_byte;
   dsf_byte_t mask_a_byte;
   dsf_byte_t mask_b_byte;

   always_comb
   begin
      live_a_byte = `DSF_RST_BYTE;
      live_b_byte = `DSF_RST_BYTE;
      flag_a_byte = `DSF_RST_BYTE;
      flag_b_byte = `DSF_RST_BYTE;
      mask_a_byte = `DSF_RST_BYTE;
      mask_b_byte = `DSF_RST_BYTE;
      live_a_byte[`DSF_BIT_SYSCAL]  = live[`DSF_SL_SYSCAL];
      live_a_byte[`DSF_BIT_REFLOS]  = live[`DSF_SL_REFLOS];
      live_a_byte[`DSF_BIT_LOCKERR] = live[`DSF_SL_LOCKERR];
      live_a_byte[`DSF_BIT_TMOUT]   = live[`DSF_SL_TMOUT];
      live_b_byte[`DSF_BIT_PLLCAL]  = live[`DSF_SL_PLLCAL];
      flag_a_byte[`DSF_BIT_SYSCAL]  = flag_q[`DSF_SL_SYSCAL];
      flag_a_byte[`DSF_BIT_REFLOS]  = flag_q[`DSF_SL_REFLOS];
      flag_a_byte[`DSF_BIT_LOCKERR] = flag_q[`DSF_SL_LOCKERR];
      flag_a_byte[`DSF_BIT_TMOUT]   = flag_q[`DSF_SL_TMOUT];
      flag_b_byte[`DSF_BIT_PLLCAL]  = flag_q[`DSF_SL_PLLCAL];
      mask_a_byte[`DSF_BIT_SYSCAL]  = mask_q[`DSF_SL_SYSCAL];
      mask_a_byte[`DSF_BIT_REFLOS]  = mask_q[`DSF_SL_REFLOS];
      mask_a_byte[`DSF_BIT_LOCKERR] = mask_q[`DSF_SL_LOCKERR];
      mask_a_byte[`DSF_BIT_TMOUT]   = mask_q[`DSF_SL_TMOUT];
      mask_b_byte[`DSF_BIT_PLLCAL]  = mask_q[`DSF_SL_PLLCAL];
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   dsf_byte_t rdata_q;
   dsf_byte_t rdata_d;

   always_comb
   begin
      rdata_d = `DSF_RST_BYTE;
      if (rd_en)
      begin
         if (hit_live_a)
         begin
            rdata_d = live_a_byte;
         end
         if (hit_live_b)
         begin
            rdata_d = live_b_byte;
         end
         if (hit_flag_a)
         begin
            rdata_d = flag_a_byte;
         end
         if (hit_flag_b)
         begin
            rdata_d = flag_b_byte;
         end
         if (hit_mask_a)
         begin
            rdata_d = mask_a_byte;
         end
         if (hit_mask_b)
         begin
            rdata_d = mask_b_byte;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         rdata_q <= `DSF_RST_BYTE;
      end
      else
      begin
         rdata_q <= rdata_d;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt
   // ----------------------------------------------------------------
   dsf_vec_t pending;
   logic     irq_n_q;
   logic     irq_n_d;

   // Masked flags still read back, they only stop driving the pin
   generate
      for (gi = 0; gi < `DSF_N_FLAGS; gi++)
      begin : g_pend
         assign pending[gi] = flag_q[gi] && !mask_q[gi];
      end
   endgenerate

   always_comb
   begin
      // Low while any unmasked flag is up, one cycle behind the flags
      irq_n_d = !(|pending);
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         irq_n_q <= 1'b1;
      end
      else
      begin
         irq_n_q <= irq_n_d;
      end
   end

   assign rdata           = rdata_q;
   assign interrupt_out_n = irq_n_q;

endmodule
`default_nettype wire

// [dsf_status_flags_sva.sv]
`timescale 1ns/100ps
`default_nettype none
module dsf_status_flags_chk
#(
   parameter int ADDR_W = 8
)
(
   input wire logic               ref_clk,
   input wire logic               reset,
   input wire logic [ADDR_W-1:0]  addr,
   input wire dsf_pkg::dsf_byte_t wdata,
   input wire logic               wr_en,
   input wire logic               rd_en,
   input wire dsf_pkg::dsf_byte_t rdata,
   input wire logic               system_calibrating,
   input wire logic               reference_signal_lost,
   input wire logic               reference_lock_error,
   input wire logic               bus_timeout_seen,
   input wire logic               pll_calibrating,
   input wire logic               interrupt_out_n
);
   import dsf_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   // ----
   // Three samples cover the two-stage synchroniser
   // ----
   property live_p(ind, a, b);
      (ind[*3] ##0 (rd_en && addr == a)) |=> rdata[b];
   endproperty
   idle_rdata_a: assert property (!rd_en |=> rdata == 8'h00) else $error("rdata not idle");
   live_syscal_a: assert property (live_p(system_calibrating, 8'h30, 0))
      else $error("live bit 0 wrong");
   live_reflos_a: assert property (live_p(reference_signal_lost, 8'h30, 2))
      else $error("live bit 2 wrong");
   live_lock_a: assert property (live_p(reference_lock_error, 8'h30, 3))
      else $error("live bit 3 wrong");
   live_tmout_a: assert property (live_p(bus_timeout_seen, 8'h30, 5))
      else $error("live timeout bit wrong");
   live_pll_a: assert property (live_p(pll_calibrating, 8'h3c, 5))
      else $error("live pll bit wrong");
   clear_refused_a: assert property ((system_calibrating[*4] ##0 (wr_en && addr == 8'h44
      && wdata == 8'h00) ##2 (rd_en && addr == 8'h44)) |=> rdata[0]) else $error("flag cleared");
   irq_release_a: assert property ($rose(interrupt_out_n) |-> $past(wr_en, 2))
      else $error("irq released without write");
   cover property (wr_en && addr == 8'h44);
   cover property (!interrupt_out_n);
   cover property (rd_en && addr == 8'h50);
endmodule
bind dsf_status_flags dsf_status_flags_chk #(.ADDR_W(ADDR_W)) chk (.ref_clk, .reset, .addr,
   .wdata, .wr_en, .rd_en, .rdata, .system_calibrating, .reference_signal_lost,
   .reference_lock_error, .bus_timeout_seen, .pll_calibrating, .interrupt_out_n);
`default_nettype wire

// [tb_dsf_status_flags.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_dsf_status_flags;
   import dsf_pkg::*;
   logic       ref_clk = 1'b0;
   logic       reset = 1'b1;
   logic [7:0] addr = 8'h00;
   dsf_byte_t  wdata = 8'h00;
   logic       wr_en = 1'b0;
   logic       rd_en = 1'b0;
   dsf_byte_t  rdata;
   logic [4:0] ind = 5'h00;
   logic       interrupt_out_n;
   int         mismatches = 0;
   int         n_checks = 0;
   logic [7:0] la [5] = '{8'h30, 8'h30, 8'h30, 8'h30, 8'h3c};
   logic [7:0] fa [5] = '{8'h44, 8'h44, 8'h44, 8'h44, 8'h50};
   logic [7:0] ma [5] = '{8'h5c, 8'h5c, 8'h5c, 8'h5c, 8'h68};
   int         bt [5] = '{0, 2, 3, 5, 5};
   always #50 ref_clk = ~ref_clk;
   dsf_status_flags uut (.ref_clk(ref_clk), .reset(reset), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .system_calibrating(ind[0]),
      .reference_signal_lost(ind[1]), .reference_lock_error(ind[2]),
      .bus_timeout_seen(ind[3]), .pll_calibrating(ind[4]), .interrupt_out_n(interrupt_out_n));
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input dsf_byte_t got, input dsf_byte_t exp);
      n_checks++;
      if (got !== exp)
         begin
         mismatches++;
         $display("MISMATCH %0t rdata %h expected %h", $time, got, exp);
         end
   endtask
   task automatic wr(input logic [7:0] a, input dsf_byte_t d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge ref_clk);
      wr_en <= 1'b0;
   endtask
   // Read data stands one cycle only, so sample just after the edge
   task automatic rd(input logic [7:0] a, input dsf_byte_t exp);
      @(posedge ref_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   task automatic wait_irq(input logic exp);
      n_checks++;
      for (int i = 0; i < 8 && interrupt_out_n !== exp; i++)
         @(posedge ref_clk) #1;
      if (interrupt_out_n !== exp)
         begin
         mismatches++;
         $display("MISMATCH %0t interrupt not %b", $time, exp);
         close_out();
         end
   endtask
   task automatic t_reset();
      rd(8'h44, 8'h00);
      rd(8'h50, 8'h00);
      rd(8'h5c, 8'h00);
      rd(8'h68, 8'h00);
      wait_irq(1'b1);
      wr(8'h30, 8'hff);
      rd(8'h30, 8'h00);
      rd(8'h31, 8'h00);
   endtask
   task automatic t_flag(input int i);
      dsf_byte_t b;
      b = dsf_byte_t'(1) << bt[i];
      @(posedge ref_clk);
      ind[i] <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rd(la[i], b);
      rd(fa[i], b);
      wait_irq(1'b0);
      wr(fa[i], 8'h00);
      rd(fa[i], b);
      @(posedge ref_clk);
      ind[i] <= 1'b0;
      repeat (4) @(posedge ref_clk);
      rd(la[i], 8'h00);
      wr(fa[i], 8'hff);
      rd(fa[i], b);
      wait_irq(1'b0);
      wr(fa[i], 8'h00);
      rd(fa[i], 8'h00);
      wait_irq(1'b1);
   endtask
   task automatic t_mask(input int i);
      dsf_byte_t b;
      b = dsf_byte_t'(1) << bt[i];
      wr(ma[i], b);
      rd(ma[i], b);
      @(posedge ref_clk);
      ind[i] <= 1'b1;
      repeat (6) @(posedge ref_clk);
      #1 wait_irq(1'b1);
      rd(fa[i], b);
      wr(ma[i], 8'h00);
      wait_irq(1'b0);
      @(posedge ref_clk);
      ind[i] <= 1'b0;
      repeat (4) @(posedge ref_clk);
      wr(fa[i], 8'h00);
      wait_irq(1'b1);
   endtask
   initial
   begin
      repeat (6) @(posedge ref_clk);
      reset <= 1'b0;
      t_reset();
      for (int i = 0; i < 5; i++)
         t_flag(i);
      t_mask(0);
      t_mask(4);
      close_out();
   end
endmodule
`default_nettype wire
